// File: hdl/int_exec_map.vh
`ifndef INT_EXEC_MAP_VH
`define INT_EXEC_MAP_VH

// operation codes on the op port
`define OP_UDIV        4'h0
`define OP_SDIV        4'h1
`define OP_SET_BIT_CNT 4'h2
`define OP_LEAD_ZERO   4'h3
`define OP_AND_NOT     4'h4
`define OP_ISO_LO_SET  4'h5
`define OP_ISO_LO_CLR  4'h6
`define OP_INV_MASK_TO 4'h7
`define OP_FILL_LO_CLR 4'h8
`define OP_FILL_LO_SET 4'h9
`define OP_FIELD_EXT   4'ha

// divide operand size codes
`define SIZE_8         2'h0
`define SIZE_16        2'h1
`define SIZE_32        2'h2
`define SIZE_64        2'h3

// divide quotient latencies in clock cycles
`define DIV_BASE_LAT   7'h08
`define DIV_BYTE_LAT   7'h14

// field-extract control operand layout
`define FEXT_START_LSB 0
`define FEXT_LEN_LSB   8
`define FEXT_FLD_W     8

`endif

// File: hdl/int_divide_and_bit_manip_unit.v
// Behaviour
// - 8-bit divide: quotient at 20, remainder +1
// - wider divide: quotient at 8 plus msb position
// - remainder one cycle after its quotient
// - quotient latency caps 23, 39, 71 cycles
// - wider-divide latency shrinks with quotient leading zeros
// - set-bit count returns number of ones
// - leading zeros counted from msb down
// - counters work on 32 or 64 bits
// - and-not: complement of a and b
// - keep only lowest set bit
// - lowest clear bit zero, others one
// - zero below lowest clear bit, ones above
// - clear below lowest zero, keep higher bits
// - set below lowest one, keep others
// - extract length bits from start, zero above
// - dividend below divisor, zero divisor or overflow take short path
`timescale 1ns/100ps
`include "int_exec_map.vh"

module int_divide_and_bit_manip_unit (
	input  wire        mclk,
	input  wire        nrst,
	input  wire        issue,
	input  wire [3:0]  op,
	input  wire [1:0]  div_size,
	input  wire        mode64,
	input  wire [63:0] src_a,
	input  wire [63:0] src_b,
	input  wire [63:0] src_hi,
	output reg         busy,
	output reg         quo_valid,
	output reg  [63:0] quo,
	output reg         rem_valid,
	output reg  [63:0] rem,
	output reg         div_error,
	output reg         bit_valid,
	output reg  [63:0] bit_result
);

	localparam ST_IDLE = 4'b0001;
	localparam ST_RUN  = 4'b0010;
	localparam ST_WAIT = 4'b0100;
	localparam ST_REM  = 4'b1000;

	function [7:0] clz128;
		input [127:0] v;
		integer i;
		reg     found;
		begin
			clz128 = 8'h00;
			found = 1'b0;
			for (i = 127; i >= 0; i = i - 1) begin
				if (!found) begin
					if (v[i])
						found = 1'b1;
					else
						clz128 = clz128 + 8'h01;
				end
			end
		end
	endfunction

	function [63:0] size_mask;
		input [1:0] s;
		begin
			case (s)
			`SIZE_8:  size_mask = 64'h0000_0000_0000_00ff;
			`SIZE_16: size_mask = 64'h0000_0000_0000_ffff;
			`SIZE_32: size_mask = 64'h0000_0000_ffff_ffff;
			default:  size_mask = 64'hffff_ffff_ffff_ffff;
			endcase
		end
	endfunction

	reg [3:0]   state;
	reg [6:0]   cnt;
	reg [6:0]   step;
	reg [127:0] part;
	reg [127:0] dd;
	reg [63:0]  qacc;
	reg         err_pre;
	reg         q_neg;
	reg         r_neg;
	reg         sgn;
	reg [1:0]   dsize;

	// operand preparation at issue
	reg [127:0] n_ext;
	reg [63:0]  d_ext;
	reg [7:0]   wsh;
	reg         n_neg;
	reg         d_neg;
	reg [127:0] n_mag;
	reg [63:0]  d_mag;
	reg [7:0]   shift_s;
	reg         ovf_pre;
	wire        is_div = (op == `OP_UDIV) || (op == `OP_SDIV);
	wire        is_sdiv = (op == `OP_SDIV);
	wire        accept = issue && is_div && (state == ST_IDLE);

	always @* begin
		case (div_size)
		`SIZE_8: begin
			n_ext = is_sdiv ? {{112{src_a[15]}}, src_a[15:0]}
				: {112'h0, src_a[15:0]};
			d_ext = is_sdiv ? {{56{src_b[7]}}, src_b[7:0]}
				: {56'h0, src_b[7:0]};
			wsh = 8'h08;
		end
		`SIZE_16: begin
			n_ext = is_sdiv ? {{96{src_hi[15]}}, src_hi[15:0], src_a[15:0]}
				: {96'h0, src_hi[15:0], src_a[15:0]};
			d_ext = is_sdiv ? {{48{src_b[15]}}, src_b[15:0]}
				: {48'h0, src_b[15:0]};
			wsh = 8'h10;
		end
		`SIZE_32: begin
			n_ext = is_sdiv ? {{64{src_hi[31]}}, src_hi[31:0], src_a[31:0]}
				: {64'h0, src_hi[31:0], src_a[31:0]};
			d_ext = is_sdiv ? {{32{src_b[31]}}, src_b[31:0]}
				: {32'h0, src_b[31:0]};
			wsh = 8'h20;
		end
		default: begin
			n_ext = {src_hi, src_a};
			d_ext = src_b;
			wsh = 8'h40;
		end
		endcase
		n_neg = is_sdiv && n_ext[127];
		d_neg = is_sdiv && d_ext[63];
		// upper word of all zeros, or of all ones in signed divide, folds to a small magnitude
		n_mag = n_neg ? (128'h0 - n_ext) : n_ext;
		d_mag = d_neg ? (64'h0 - d_ext) : d_ext;
		ovf_pre = (n_mag >> wsh) >= {64'h0, d_mag};
		// iterations only cover quotient bits that can be set
		shift_s = clz128({64'h0, d_mag}) - clz128(n_mag);
	end

	// result shaping and latency target while waiting
	reg [63:0] q_fin;
	reg [63:0] r_fin;
	reg [63:0] q_lim;
	reg        err_fin;
	reg [7:0]  q_pos;
	reg [6:0]  target;

	always @* begin
		q_fin = (q_neg ? (64'h0 - qacc) : qacc) & size_mask(dsize);
		r_fin = (r_neg ? (64'h0 - part[63:0]) : part[63:0])
			& size_mask(dsize);
		q_lim = (size_mask(dsize) >> 1) + {63'h0, q_neg};
		err_fin = err_pre || (sgn && (qacc > q_lim));
		q_pos = 8'h7f - clz128({64'h0, qacc});
		if (dsize == `SIZE_8)
			target = `DIV_BYTE_LAT;
		else if (qacc == 64'h0)
			target = `DIV_BASE_LAT;
		else
			// quotient below 2^64 keeps this at or under 71
			target = `DIV_BASE_LAT + q_pos[6:0];
	end

	// divider sequencer
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			state <= ST_IDLE;
			cnt <= 7'h00;
			step <= 7'h00;
			part <= 128'h0;
			dd <= 128'h0;
			qacc <= 64'h0;
			err_pre <= 1'b0;
			q_neg <= 1'b0;
			r_neg <= 1'b0;
			sgn <= 1'b0;
			dsize <= 2'h0;
			busy <= 1'b0;
			quo_valid <= 1'b0;
			quo <= 64'h0;
			rem_valid <= 1'b0;
			rem <= 64'h0;
			div_error <= 1'b0;
		end else begin
			case (state)
			ST_IDLE: begin
				rem_valid <= 1'b0;
				div_error <= 1'b0;
				if (accept) begin
					busy <= 1'b1;
					cnt <= 7'h01;
					sgn <= is_sdiv;
					q_neg <= n_neg ^ d_neg;
					r_neg <= n_neg;
					dsize <= div_size;
					qacc <= 64'h0;
					part <= n_mag;
					dd <= {64'h0, d_mag} << shift_s;
					step <= shift_s[6:0];
					err_pre <= (d_mag == 64'h0) || ovf_pre;
					if ((d_mag == 64'h0) || ovf_pre
						|| (n_mag < {64'h0, d_mag}))
						state <= ST_WAIT;
					else
						state <= ST_RUN;
				end
			end
			ST_RUN: begin
				cnt <= cnt + 7'h01;
				if (part >= dd) begin
					part <= part - dd;
					qacc[step[5:0]] <= 1'b1;
				end
				dd <= dd >> 1;
				if (step == 7'h00)
					state <= ST_WAIT;
				else
					step <= step - 7'h01;
			end
			ST_WAIT: begin
				cnt <= cnt + 7'h01;
				if (cnt == target) begin
					quo_valid <= 1'b1;
					quo <= err_fin ? 64'h0 : q_fin;
					div_error <= err_fin;
					state <= ST_REM;
				end
			end
			ST_REM: begin
				quo_valid <= 1'b0;
				rem_valid <= 1'b1;
				rem <= div_error ? 64'h0 : r_fin;
				busy <= 1'b0;
				state <= ST_IDLE;
			end
			default: begin
				state <= ST_IDLE;
				busy <= 1'b0;
				quo_valid <= 1'b0;
				rem_valid <= 1'b0;
			end
			endcase
		end
	end

	// single-cycle bit operations
	reg [63:0] wmask;
	reg [63:0] x;
	reg [63:0] y;
	reg [63:0] fld_mask;
	reg [7:0]  fld_start;
	reg [7:0]  fld_len;
	reg [6:0]  ones;
	reg [7:0]  lz;
	reg [63:0] next_bit_result;
	integer    k;

	always @* begin
		wmask = mode64 ? 64'hffff_ffff_ffff_ffff
			: 64'h0000_0000_ffff_ffff;
		x = src_a & wmask;
		y = src_b & wmask;
		ones = 7'h00;
		for (k = 0; k < 64; k = k + 1)
			ones = ones + {6'h00, x[k]};
		// zero extension adds 32 leading zeros in 32-bit mode
		lz = clz128({x, 64'h0}) - (mode64 ? 8'h00 : 8'h20);
		if (x == 64'h0)
			lz = mode64 ? 8'h40 : 8'h20;
		// length sits in the byte above the start index
		fld_start = src_b[`FEXT_START_LSB +: `FEXT_FLD_W];
		fld_len = src_b[`FEXT_LEN_LSB +: `FEXT_FLD_W];
		fld_mask = (fld_len >= 8'h40) ? 64'hffff_ffff_ffff_ffff
			: ((64'h1 << fld_len) - 64'h1);
		case (op)
		`OP_SET_BIT_CNT: next_bit_result = {57'h0, ones};
		`OP_LEAD_ZERO:   next_bit_result = {56'h0, lz};
		`OP_AND_NOT:     next_bit_result = ~x & y;
		`OP_ISO_LO_SET:  next_bit_result = x & (64'h0 - x);
		`OP_ISO_LO_CLR:  next_bit_result = x | ~(x + 64'h1);
		`OP_INV_MASK_TO: next_bit_result = ~x | (x + 64'h1);
		`OP_FILL_LO_CLR: next_bit_result = x & (x + 64'h1);
		`OP_FILL_LO_SET: next_bit_result = x | (x - 64'h1);
		`OP_FIELD_EXT:
			next_bit_result = (x >> fld_start) & fld_mask;
		default:         next_bit_result = 64'h0;
		endcase
		// 32-bit mode wraps arithmetic and zeroes the upper word
		next_bit_result = next_bit_result & wmask;
	end

	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			bit_valid <= 1'b0;
			bit_result <= 64'h0;
		end else begin
			bit_valid <= issue && !is_div;
			if (issue && !is_div)
				bit_result <= next_bit_result;
		end
	end

endmodule // int_divide_and_bit_manip_unit

// File: testbench/issue_model.sv
`timescale 1ns/100ps
module issue_model (
	input  wire        mclk,
	output reg         issue,
	output reg  [3:0]  op,
	output reg  [1:0]  div_size,
	output reg         mode64,
	output reg  [63:0] src_a,
	output reg  [63:0] src_b,
	output reg  [63:0] src_hi
);
	initial begin
		issue = 1'b0;
		{op, div_size, mode64, src_a, src_b, src_hi} = 0;
	end
	// one-cycle request, operands scrambled once released
	task send(input [3:0] o, input [1:0] s, input m, input [63:0] a,
		input [63:0] b, input [63:0] h);
		begin
			@(negedge mclk);
			{issue, op, div_size, mode64} = {1'b1, o, s, m};
			{src_a, src_b, src_hi} = {a, b, h};
			@(negedge mclk);
			issue = 1'b0;
			{src_a, src_b, src_hi} = ~{a, b, h};
		end
	endtask
	task send_ext(input [63:0] a, input [7:0] start, input [7:0] len);
		send(4'ha, 2'h0, 1'b1, a, {48'h0, len, start}, 64'h0);
	endtask
endmodule // issue_model

// File: testbench/int_div_chk.sv
`timescale 1ns/100ps
module int_div_chk (
	input wire        mclk,
	input wire        nrst,
	input wire        issue,
	input wire [3:0]  op,
	input wire [1:0]  div_size,
	input wire        mode64,
	input wire [63:0] src_a,
	input wire [63:0] src_b,
	input wire [63:0] src_hi,
	input wire        busy,
	input wire        quo_valid,
	input wire [63:0] quo,
	input wire        rem_valid,
	input wire [63:0] rem,
	input wire        div_error,
	input wire        bit_valid,
	input wire [63:0] bit_result
);
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	wire go_div = issue && op < 4'h2 && !busy;
	// strobe rises at edge L, so it is first sampled high one edge later
	a_byte_latency: assert property (
		go_div && div_size == 2'h0 |-> ##21 quo_valid)
		else $error("byte divide latency wrong");
	a_cap_sixteen: assert property (
		go_div && div_size == 2'h1 |-> ##[9:24] quo_valid)
		else $error("16-bit divide latency out of range");
	a_cap_thirty_two: assert property (
		go_div && div_size == 2'h2 |-> ##[9:40] quo_valid)
		else $error("32-bit divide latency out of range");
	a_cap_sixty_four: assert property (
		go_div && div_size == 2'h3 |-> ##[9:72] quo_valid)
		else $error("64-bit divide latency out of range");
	a_rem_follows: assert property (
		quo_valid |=> rem_valid && !quo_valid)
		else $error("remainder not one cycle after quotient");
	a_split_strobes: assert property (
		rem_valid |-> $past(quo_valid) && !busy)
		else $error("remainder strobe without quotient strobe");
	a_quo_busy: assert property (quo_valid |-> busy)
		else $error("quotient strobe outside busy");
	a_bit_answer: assert property (
		issue && op > 4'h1 |=> bit_valid)
		else $error("bit result strobe missing");
	a_lzc_empty: assert property (
		bit_valid && $past(op) == 4'h3 && $past(src_a) == 64'h0
		|-> bit_result == ($past(mode64) ? 64'h40 : 64'h20))
		else $error("leading zero count of zero wrong");
	a_and_not: assert property (
		bit_valid && $past(op) == 4'h4 && $past(mode64)
		|-> bit_result == (~$past(src_a) & $past(src_b)))
		else $error("and-not result wrong");
endmodule // int_div_chk
bind int_divide_and_bit_manip_unit int_div_chk chk_u (.mclk(mclk), .nrst(nrst),
	.issue(issue), .op(op), .div_size(div_size), .mode64(mode64),
	.src_a(src_a), .src_b(src_b), .src_hi(src_hi), .busy(busy),
	.quo_valid(quo_valid), .quo(quo), .rem_valid(rem_valid), .rem(rem),
	.div_error(div_error), .bit_valid(bit_valid), .bit_result(bit_result));

// File: testbench/tb_int_divide_and_bit_manip_unit.sv
`timescale 1ns/100ps
module tb_int_divide_and_bit_manip_unit;
	reg         mclk;
	reg         nrst;
	wire        issue, mode64, busy, quo_valid, rem_valid, div_error, bit_valid;
	wire [3:0]  op;
	wire [1:0]  div_size;
	wire [63:0] src_a, src_b, src_hi, quo, rem, bit_result;
	integer     fail_count;
	integer     num_checks;
	localparam [63:0] X = 64'h0000_0100_0000_00a7;
	issue_model pm (.mclk(mclk), .issue(issue), .op(op), .div_size(div_size),
		.mode64(mode64), .src_a(src_a), .src_b(src_b), .src_hi(src_hi));
	int_divide_and_bit_manip_unit dut_u (.mclk(mclk), .nrst(nrst),
		.issue(issue), .op(op), .div_size(div_size), .mode64(mode64),
		.src_a(src_a), .src_b(src_b), .src_hi(src_hi), .busy(busy),
		.quo_valid(quo_valid), .quo(quo), .rem_valid(rem_valid), .rem(rem),
		.div_error(div_error), .bit_valid(bit_valid), .bit_result(bit_result));
	always #2 mclk = ~mclk;
	task chk(input string name, input [63:0] exp, input [63:0] got);
		begin
			num_checks = num_checks + 1;
			if (got !== exp) begin
				fail_count = fail_count + 1;
				$display("[ERR] %0s exp %h got %h", name, exp, got);
			end
		end
	endtask
	task wrap_up;
		begin
			if (fail_count == 0 && num_checks > 0)
				$display("Run complete: PASS");
			else
				$display("Run complete: FAIL");
			$finish;
		end
	endtask
	task do_div(input [3:0] o, input [1:0] s, input [63:0] h, input [63:0] a,
		input [63:0] b, input [63:0] eq, input [63:0] er, input [63:0] el,
		input ee);
		integer n;
		begin
			pm.send(o, s, 1'b0, a, b, h);
			chk("busy_on", 1, busy);
			n = 0;
			while (quo_valid !== 1'b1 && n < 100) begin
				@(posedge mclk);
				#1;
				n = n + 1;
			end
			chk("latency", el, n);
			if (n == 100) wrap_up;
			chk("quo", eq, quo);
			chk("err", ee, div_error);
			@(posedge mclk);
			#1;
			chk("rem_vld", 1, rem_valid);
			chk("rem", er, rem);
			chk("rem_err", ee, div_error);
			chk("busy", 0, busy);
		end
	endtask
	task do_bit(input [3:0] o, input m, input [63:0] a, input [63:0] b,
		input [63:0] e);
		begin
			pm.send(o, 2'h0, m, a, b, 64'h0);
			chk("bit_vld", 1, bit_valid);
			chk("bit", e, bit_result);
		end
	endtask
	task t_byte_div;
		begin
			do_div(4'h0, 2'h0, 0, 100, 7, 14, 2, 20, 1'b0);
			do_div(4'h1, 2'h0, 0, 16'hff9c, 7, 8'hf2, 8'hfe, 20, 1'b0);
		end
	endtask
	task t_wide_div;
		begin
			do_div(4'h0, 2'h1, 0, 100, 7, 14, 2, 11, 1'b0);
			do_div(4'h0, 2'h1, 0, 1000, 7, 8'h8e, 6, 15, 1'b0);
			do_div(4'h1, 2'h1, 16'hffff, 16'hff9c, 7,
				16'hfff2, 16'hfffe, 11, 1'b0);
			do_div(4'h0, 2'h2, 0, 32'hffffffff, 1,
				32'hffffffff, 0, 39, 1'b0);
			do_div(4'h0, 2'h3, 0, ~64'h0, 1, ~64'h0, 0, 71, 1'b0);
		end
	endtask
	// divisor zero and signed overflow both flag, results forced to zero
	task t_div_err;
		begin
			do_div(4'h0, 2'h1, 0, 100, 0, 0, 0, 8, 1'b1);
			do_div(4'h1, 2'h0, 0, 16'hff80, 8'hff, 0, 0, 20, 1'b1);
		end
	endtask
	task t_bit_ops;
		begin
			do_bit(4'h2, 1'b1, X, 0, 6);
			do_bit(4'h2, 1'b0, X, 0, 5);
			do_bit(4'h3, 1'b1, X, 0, 23);
			do_bit(4'h3, 1'b0, X, 0, 24);
			do_bit(4'h3, 1'b1, 0, 0, 64);
			do_bit(4'h3, 1'b0, 0, 0, 32);
			do_bit(4'h4, 1'b1, X, 64'hffff, 64'hff58);
			do_bit(4'h5, 1'b1, X, 0, 1);
			do_bit(4'h6, 1'b1, X, 0, ~64'h8);
			do_bit(4'h6, 1'b0, X, 0, 64'h0000_0000_ffff_fff7);
			do_bit(4'h7, 1'b1, X, 0, ~64'h7);
			do_bit(4'h8, 1'b1, X, 0, X & ~64'h7);
			do_bit(4'h8, 1'b1, ~64'h0, 0, 0);
			do_bit(4'h9, 1'b1, X ^ 64'h57, 0, X | 64'h5f);
			do_bit(4'h9, 1'b1, 0, 0, ~64'h0);
			pm.send_ext(X, 8'd36, 8'd8);
			chk("ext_vld", 1, bit_valid);
			chk("extract", 64'h10, bit_result);
		end
	endtask
	initial begin
		mclk = 1'b0;
		nrst = 1'b0;
		fail_count = 0;
		num_checks = 0;
		repeat (2) @(negedge mclk);
		nrst = 1'b1;
		t_byte_div;
		t_wide_div;
		t_div_err;
		t_bit_ops;
		wrap_up;
	end
endmodule // tb_int_divide_and_bit_manip_unit
